// >>> design/ccp_pkg.sv
// package: constants and types for the timer and input capture core
package ccp_pkg;
  localparam int CTR_W = 16;

  // register offsets
  localparam logic [3:0] OFS_CONTROL_ONE_LOW  = 4'h0;
  localparam logic [3:0] OFS_CONTROL_ONE_HIGH = 4'h1;
  localparam logic [3:0] OFS_STATUS_LOW       = 4'h2;
  localparam logic [3:0] OFS_LOW_COUNTER      = 4'h3;
  localparam logic [3:0] OFS_HIGH_COUNTER     = 4'h4;
  localparam logic [3:0] OFS_LOW_PERIOD       = 4'h5;
  localparam logic [3:0] OFS_HIGH_PERIOD      = 4'h6;
  localparam logic [3:0] OFS_CAPTURE_LOW      = 4'h7;
  localparam logic [3:0] OFS_CAPTURE_HIGH     = 4'h8;
  localparam logic [3:0] OFS_INT_STATUS       = 4'h9;
  localparam logic [3:0] OFS_INT_ENABLE       = 4'hA;
  localparam logic [3:0] OFS_INT_CLEAR        = 4'hB;

  // field positions
  localparam int CON1L_OPSEL_LSB    = 0;
  localparam int CON1L_CAPSEL_BIT   = 4;
  localparam int CON1L_WIDE_BIT     = 5;
  localparam int CON1L_CLKSEL_LSB   = 8;
  localparam int CON1L_ON_BIT       = 15;
  localparam int CON1H_SRC_LSB      = 0;
  localparam int CON1H_TRIGGER_ENABLE_BIT   = 7;
  localparam int STATL_TRIGGER_CLEAR_BIT    = 5;
  localparam int STATL_TRIG_BIT     = 7;
  localparam int STATL_FIFO_NE_BIT  = 0;
  localparam int STATL_FIFO_OVF_BIT = 1;

  // reset values
  localparam logic [15:0] CON1L_RESET  = 16'h0000;
  localparam logic [15:0] CON1H_RESET  = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;

  // FIFO depth, reserved source code, clock select and prescale counts
  localparam int          FIFO_DEPTH     = 4;
  localparam logic [4:0]  SRC_FORBIDDEN  = 5'h1F;
  localparam logic [2:0]  CLKSEL_SYSCLK  = 3'h0;
  localparam logic [3:0]  PRESCALE_4     = 4'h3;
  localparam logic [3:0]  PRESCALE_16    = 4'hF;

  typedef enum logic [3:0] {
    OP_EDGE     = 4'h0,
    OP_RISE     = 4'h1,
    OP_FALL     = 4'h2,
    OP_BOTH     = 4'h3,
    OP_RISE4    = 4'h4,
    OP_RISE16   = 4'h5
  } op_sel_t;

  // interrupt bit layout
  typedef struct packed {
    logic capture;
    logic high_period;
    logic low_period;
  } irq_bits_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;
endpackage

// >>> design/capture_edge.sv
// capture event generator: synchroniser, edge detect, prescaler
`timescale 1ns/1ps
`default_nettype none
module capture_edge (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  input  wire logic             pin_in,
  input  wire logic             enable_in,
  input  wire logic [3:0]       mode_in,
  output logic                  event_out
);
  import ccp_pkg::*;

  logic       meta_q;
  logic       sync_q;
  logic       prev_q;
  logic [3:0] pre_q;
  logic       rise;
  logic       fall;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

  // prescaler only counts rising edges; cleared while idle so count restarts
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_q <= 4'h0;
    end else if (!enable_in) begin
      pre_q <= 4'h0;
    end else if (rise) begin
      pre_q <= pre_q + 4'h1;
    end
  end

  always_comb begin
    event_out = 1'b0;
    if (enable_in) begin
      unique case (mode_in)
        OP_EDGE:   event_out = rise | fall;
        OP_RISE:   event_out = rise;
        OP_FALL:   event_out = fall;
        OP_BOTH:   event_out = rise | fall;
        OP_RISE4:  event_out = rise && (pre_q[1:0] == PRESCALE_4[1:0]);
        OP_RISE16: event_out = rise && (pre_q == PRESCALE_16);
        default:   event_out = 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> design/ccp_timer.sv
// timer and input capture core with register port and interrupt
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ccp_timer #(
  parameter int DEPTH = ccp_pkg::FIFO_DEPTH
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  input  wire ccp_pkg::reg_req_t req_in,
  output logic [15:0]           rdata_out,
  input  wire logic [31:0]      sync_sources_in,
  input  wire logic             capture_pin_in,
  output logic                  sync_out,
  output logic                  compare_event_out,
  output logic                  irq_out
);
  import ccp_pkg::*;

  // pointer wrap bit trick only works for power-of-two depths
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("DEPTH must be a power of two, at least 2");
  end

  localparam int PW = $clog2(DEPTH);

  logic [15:0] con1l_q;
  logic [15:0] con1h_q;
  logic [15:0] low_counter_q;
  logic [15:0] high_counter_q;
  logic [15:0] low_period_q;
  logic [15:0] high_period_q;
  logic        triggered_status_q;
  logic [31:0] cap_timer_q;
  logic [31:0] cap_view_q;
  logic [31:0] fifo_q [DEPTH];
  logic [PW:0] wp_q;
  logic [PW:0] rp_q;
  logic        ovf_q;
  logic [31:0] cap_head_q;
  irq_bits_t   int_status_q;
  irq_bits_t   int_enable_q;
  logic [15:0] rdata_q;
  logic        src_meta_q;
  logic        src_sync_q;
  logic        src_prev_q;

  logic        wide;
  logic        capture_mode;
  logic        timer_mode;
  logic        trigger_en;
  logic        src_pulse;
  logic        low_match;
  logic        high_match;
  logic        wide_match;
  logic        low_event;
  logic        high_event;
  logic        held;
  logic        clear_trig;
  logic        cap_event;
  logic        fifo_full;
  logic        fifo_empty;
  logic        pop;
  logic        wr;
  logic        rd;
  logic [4:0]  src_sel;
  irq_bits_t   ev;
  irq_bits_t   clr;

  assign wr           = req_in.wr;
  assign rd           = req_in.rd;
  assign wide         = con1l_q[CON1L_WIDE_BIT];
  assign capture_mode = con1l_q[CON1L_ON_BIT] & con1l_q[CON1L_CAPSEL_BIT];
  assign timer_mode   = con1l_q[CON1L_ON_BIT] & ~con1l_q[CON1L_CAPSEL_BIT]
                        & (con1l_q[CON1L_OPSEL_LSB +: 4] == 4'h0);
  assign trigger_en   = con1h_q[CON1H_TRIGGER_ENABLE_BIT];
  assign src_sel      = con1h_q[CON1H_SRC_LSB +: 5];

  // sources may come from other blocks or pins; synchronise before use
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      src_meta_q <= 1'b0;
      src_sync_q <= 1'b0;
      src_prev_q <= 1'b0;
    end else begin
      src_meta_q <= sync_sources_in[src_sel];
      src_sync_q <= src_meta_q;
      src_prev_q <= src_sync_q;
    end
  end

  // code 11111 is left to software to avoid in sync mode; treated as no source
  assign src_pulse = src_sync_q & ~src_prev_q & (src_sel != SRC_FORBIDDEN);

  assign clear_trig = wr && (req_in.addr == OFS_STATUS_LOW) && req_in.wdata[STATL_TRIGGER_CLEAR_BIT];
  // trigger hold only meaningful on system clock base
  assign held = trigger_en && !triggered_status_q
                && (con1l_q[CON1L_CLKSEL_LSB +: 3] == CLKSEL_SYSCLK);

  assign low_match  = low_counter_q == low_period_q;
  assign high_match = high_counter_q == high_period_q;
  assign wide_match = low_match && high_match;
  assign low_event  = timer_mode && !held && (wide ? wide_match : low_match);
  assign high_event = timer_mode && !wide && high_match;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      triggered_status_q <= 1'b0;
    end else if (timer_mode && trigger_en && src_pulse) begin
      triggered_status_q <= 1'b1;
    end else if (clear_trig) begin
      triggered_status_q <= 1'b0;
    end
  end

  // primary timer (low half); sync pulses also clear the high counter in wide mode
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      low_counter_q <= 16'h0000;
    end else if (wr && req_in.addr == OFS_LOW_COUNTER) begin
      low_counter_q <= req_in.wdata;
    end else if (timer_mode) begin
      if (held || (trigger_en && clear_trig)) begin
        low_counter_q <= 16'h0000;
      end else if (!trigger_en && src_pulse) begin
        low_counter_q <= 16'h0000;
      end else if (wide ? wide_match : low_match) begin
        low_counter_q <= 16'h0000;
      end else begin
        low_counter_q <= low_counter_q + 16'h0001;
      end
    end
  end

  // secondary timer, or upper half in wide mode
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      high_counter_q <= 16'h0000;
    end else if (wr && req_in.addr == OFS_HIGH_COUNTER) begin
      high_counter_q <= req_in.wdata;
    end else if (timer_mode) begin
      if (wide) begin
        if (held || (trigger_en && clear_trig) || (!trigger_en && src_pulse) || wide_match) begin
          high_counter_q <= 16'h0000;
        end else if (low_counter_q == 16'hFFFF) begin
          high_counter_q <= high_counter_q + 16'h0001;
        end
      end else if (high_match) begin
        high_counter_q <= 16'h0000;
      end else begin
        high_counter_q <= high_counter_q + 16'h0001;
      end
    end
  end

  // control low: counters written before wide select would keep dual-mode meaning
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      con1l_q <= CON1L_RESET;
    end else if (wr && req_in.addr == OFS_CONTROL_ONE_LOW) begin
      con1l_q <= req_in.wdata;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      con1h_q <= CON1H_RESET;
    end else if (wr && req_in.addr == OFS_CONTROL_ONE_HIGH) begin
      con1h_q <= req_in.wdata;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      low_period_q <= PERIOD_RESET;
    end else if (wr && req_in.addr == OFS_LOW_PERIOD) begin
      low_period_q <= req_in.wdata;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      high_period_q <= PERIOD_RESET;
    end else if (wr && req_in.addr == OFS_HIGH_PERIOD) begin
      high_period_q <= req_in.wdata;
    end
  end

  // enables only gate the output, status keeps collecting
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      int_enable_q <= '0;
    end else if (wr && req_in.addr == OFS_INT_ENABLE) begin
      int_enable_q <= irq_bits_t'(req_in.wdata[2:0]);
    end
  end

  capture_edge u_edge (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .pin_in     (capture_pin_in),
    .enable_in  (capture_mode),
    .mode_in    (con1l_q[CON1L_OPSEL_LSB +: 4]),
    .event_out  (cap_event)
  );

  // dedicated capture time base, free running while capture is active
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cap_timer_q <= 32'h0000_0000;
    end else if (!capture_mode) begin
      cap_timer_q <= 32'h0000_0000;
    end else begin
      cap_timer_q[15:0] <= cap_timer_q[15:0] + 16'h0001;
      if (wide && cap_timer_q[15:0] == 16'hFFFF) begin
        cap_timer_q[31:16] <= cap_timer_q[31:16] + 16'h0001;
      end else if (!wide) begin
        cap_timer_q[31:16] <= 16'h0000;
      end
    end
  end

  // one extra stage of delay for the software view
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cap_view_q <= 32'h0000_0000;
    end else begin
      cap_view_q <= cap_timer_q;
    end
  end

  assign fifo_full  = (wp_q[PW] != rp_q[PW]) && (wp_q[PW-1:0] == rp_q[PW-1:0]);
  assign fifo_empty = wp_q == rp_q;
  // high word read pops, so read low word first
  assign pop = rd && (req_in.addr == OFS_CAPTURE_HIGH) && !fifo_empty;

  always_ff @(posedge sys_clk_in) begin
    if (cap_event && !fifo_full) begin
      fifo_q[wp_q[PW-1:0]] <= cap_timer_q;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wp_q  <= '0;
      rp_q  <= '0;
      ovf_q <= 1'b0;
    end else begin
      if (cap_event && !fifo_full) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      // overflow drops the new capture, keeps older ones
      if (cap_event && fifo_full) begin
        ovf_q <= 1'b1;
      end else if (clear_trig && req_in.wdata[STATL_FIFO_OVF_BIT]) begin
        ovf_q <= 1'b0;
      end
    end
  end

  always_comb begin
    cap_head_q = fifo_q[rp_q[PW-1:0]];
  end

  assign ev  = '{capture: cap_event, high_period: high_event, low_period: low_event};
  assign clr = (wr && req_in.addr == OFS_INT_CLEAR) ? irq_bits_t'(req_in.wdata[2:0]) : '0;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      int_status_q <= '0;
    end else begin
      int_status_q <= (int_status_q & ~clr) | ev; // set wins over clear
    end
  end

  // secondary match never reaches sync out
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_out <= 1'b0;
    end else begin
      sync_out <= low_event;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      compare_event_out <= 1'b0;
    end else begin
      compare_event_out <= wide ? low_event : high_event;
    end
  end

  // built from next status so the level tracks the sticky bits without lag
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |((int_status_q & ~clr | ev) & int_enable_q);
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= 16'h0000;
    end else if (rd) begin
      unique case (req_in.addr)
        OFS_CONTROL_ONE_LOW:  rdata_q <= con1l_q;
        OFS_CONTROL_ONE_HIGH: rdata_q <= con1h_q;
        OFS_STATUS_LOW:       rdata_q <= {8'h00, triggered_status_q, 5'h00, ovf_q, ~fifo_empty};
        OFS_LOW_COUNTER:      rdata_q <= capture_mode ? cap_view_q[15:0] : low_counter_q;
        OFS_HIGH_COUNTER:     rdata_q <= capture_mode ? cap_view_q[31:16] : high_counter_q;
        OFS_LOW_PERIOD:       rdata_q <= low_period_q;
        OFS_HIGH_PERIOD:      rdata_q <= high_period_q;
        OFS_CAPTURE_LOW:      rdata_q <= cap_head_q[15:0];
        OFS_CAPTURE_HIGH:     rdata_q <= cap_head_q[31:16];
        OFS_INT_STATUS:       rdata_q <= {13'h0000, int_status_q};
        OFS_INT_ENABLE:       rdata_q <= {13'h0000, int_enable_q};
        default:              rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign rdata_out = rdata_q;
endmodule
`default_nettype wire

// >>> sim/ccp_timer_properties.sv
// checker: port-level properties of the timer core
`timescale 1ns/1ps
`default_nettype none
module ccp_timer_properties (
  input wire logic              sys_clk_in,
  input wire logic              rst_in,
  input wire ccp_pkg::reg_req_t req_in,
  input wire logic [15:0]       rdata_out,
  input wire logic              sync_out,
  input wire logic              compare_event_out,
  input wire logic              irq_out
);
  import ccp_pkg::*;
  logic on_q;
  // shadow of the on bit, so quiet checks need no internal probe
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      on_q <= 1'b0;
    end else if (req_in.wr && req_in.addr == OFS_CONTROL_ONE_LOW) begin
      on_q <= req_in.wdata[CON1L_ON_BIT];
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_wr(a);
    req_in.wr && req_in.addr == a;
  endsequence
  sequence s_rd(a);
    req_in.rd && req_in.addr == a;
  endsequence
  property p_back(a);
    s_wr(a) ##1 s_rd(a) |=> rdata_out == $past(req_in.wdata, 2);
  endproperty
  a_read_idle_zero: assert property (!$past(req_in.rd) |-> rdata_out == 16'h0000)
    else $error("read data without a read");
  a_unmapped_zero: assert property ($past(req_in.rd) && ($past(req_in.addr) > OFS_INT_CLEAR) |->
    rdata_out == 16'h0000) else $error("unmapped read not zero");
  a_ctrl_readback: assert property (s_wr(OFS_CONTROL_ONE_LOW) ##1 s_rd(OFS_CONTROL_ONE_LOW) |=>
    (rdata_out & 16'h873F) == ($past(req_in.wdata, 2) & 16'h873F)) else $error("control readback");
  a_low_period_back: assert property (p_back(OFS_LOW_PERIOD))
    else $error("low period readback");
  a_high_period_back: assert property (p_back(OFS_HIGH_PERIOD))
    else $error("high period readback");
  a_irq_disable: assert property (s_wr(OFS_INT_ENABLE) ##0 (req_in.wdata == 16'h0000) |-> ##2 !irq_out)
    else $error("irq with enables cleared");
  a_off_no_sync: assert property (!on_q [*3] |-> !sync_out)
    else $error("sync pulse while off");
  a_off_no_compare: assert property (!on_q [*3] |-> !compare_event_out)
    else $error("compare pulse while off");
endmodule
bind ccp_timer ccp_timer_properties ccp_timer_properties_inst (
  .sys_clk_in        (sys_clk_in),
  .rst_in            (rst_in),
  .req_in            (req_in),
  .rdata_out         (rdata_out),
  .sync_out          (sync_out),
  .compare_event_out (compare_event_out),
  .irq_out           (irq_out)
);
`default_nettype wire

// >>> sim/ccp_far_end.sv
// far-side model: sync sources and capture pin
`timescale 1ns/1ps
`default_nettype none
module ccp_far_end (
  input  wire logic   sys_clk_in,
  output logic [31:0] src_out,
  output logic        pin_out
);
  initial begin
    src_out = 32'h0000_0000;
    pin_out = 1'b0;
  end
  // slow edges: 4 high, 4 low, so the synchroniser never misses one
  task automatic pulse_src(input logic [4:0] idx);
    if (idx != 5'h1F) begin
      @(posedge sys_clk_in) src_out[idx] <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      src_out[idx] <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
    end
  endtask
  task automatic pulse_pin(input int k);
    repeat (k) begin
      @(posedge sys_clk_in) pin_out <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      pin_out <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
    end
  endtask
endmodule
`default_nettype wire

// >>> sim/ccp_timer_tb.sv
// testbench: register-level tests of the timer core
`timescale 1ns/1ps
`default_nettype none
module ccp_timer_tb;
  import ccp_pkg::*;
  logic        sys_clk_in;
  logic        rst_in;
  reg_req_t    req;
  logic [15:0] rdata;
  logic [31:0] src;
  logic        pin;
  logic        sync_o;
  logic        cmp_o;
  logic        irq_o;
  int          num_errors;
  int          checked;
  int          ticks;
  int          n;
  logic [15:0] v;
  op_sel_t     modes [6] = '{OP_EDGE, OP_RISE, OP_FALL, OP_BOTH, OP_RISE4, OP_RISE16};
  int          rises [6] = '{1, 1, 1, 1, 4, 16};

  ccp_timer ccp_timer_inst (
    .sys_clk_in        (sys_clk_in),
    .rst_in            (rst_in),
    .req_in            (req),
    .rdata_out         (rdata),
    .sync_sources_in   (src),
    .capture_pin_in    (pin),
    .sync_out          (sync_o),
    .compare_event_out (cmp_o),
    .irq_out           (irq_o)
  );
  ccp_far_end ccp_far_end_inst (
    .sys_clk_in (sys_clk_in),
    .src_out    (src),
    .pin_out    (pin)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // accesses leave the strobe up; the next call or cyc drops it
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk_in);
  endtask
  task automatic rd(input logic [3:0] a);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge sys_clk_in);
    #1 v = rdata;
  endtask
  task automatic cyc(input int k);
    req <= '0;
    repeat (k) @(posedge sys_clk_in);
  endtask
  task automatic wait_pulse(input bit cmp);
    req <= '0;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      #1 n++;
    end while (((cmp ? cmp_o : sync_o) !== 1'b1) && n < 200);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ceiling well above the few hundred cycles the tests need
  always @(posedge sys_clk_in) begin
    ticks++;
    if (ticks == 8000) begin
      num_errors++;
      end_sim();
    end
  end

  initial begin
    req = '0;
    rst_in = 1'b1;
    repeat (4) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    rd(OFS_CONTROL_ONE_LOW);
    chk("con1l", v, CON1L_RESET);
    rd(OFS_HIGH_PERIOD);
    chk("hper", v, PERIOD_RESET);
    rd(4'hF);
    chk("unmapped", v, 16'h0000);
    wr(OFS_LOW_PERIOD, 16'h0004);
    rd(OFS_LOW_PERIOD);
    chk("lper", v, 16'h0004);
    wr(OFS_HIGH_PERIOD, 16'h0006);
    rd(OFS_HIGH_PERIOD);
    chk("hper back", v, 16'h0006);
    wr(OFS_INT_ENABLE, 16'h0003);
    wr(OFS_CONTROL_ONE_LOW, 16'h8000);
    rd(OFS_CONTROL_ONE_LOW);
    chk("con1l on", v, 16'h8000);
    wait_pulse(0);
    wait_pulse(0);
    chk("sync gap", 16'(n), 16'h0005);
    wait_pulse(1);
    wait_pulse(1);
    chk("cmp gap", 16'(n), 16'h0007);
    chk("irq", {15'h0, irq_o}, 16'h0001);
    rd(OFS_INT_STATUS);
    chk("int stat", v & 16'h0003, 16'h0003);
    wr(OFS_INT_ENABLE, 16'h0000);
    cyc(3);
    chk("irq off", {15'h0, irq_o}, 16'h0000);
    wr(OFS_CONTROL_ONE_LOW, 16'h0000);
    cyc(4);
    wr(OFS_INT_CLEAR, 16'h0007);
    rd(OFS_INT_STATUS);
    chk("int clr", v, 16'h0000);
    // wide select first, then counters and periods
    wr(OFS_CONTROL_ONE_LOW, 16'h0020);
    wr(OFS_LOW_COUNTER, 16'hFFF8);
    wr(OFS_HIGH_COUNTER, 16'h0000);
    wr(OFS_HIGH_PERIOD, 16'h0001);
    wr(OFS_LOW_PERIOD, 16'h0010);
    wr(OFS_CONTROL_ONE_LOW, 16'h8020);
    cyc(14);
    rd(OFS_HIGH_COUNTER);
    chk("carry", v, 16'h0001);
    wait_pulse(0);
    chk("wide cmp", {15'h0, cmp_o}, 16'h0001);
    wr(OFS_CONTROL_ONE_LOW, 16'h0000);
    wr(OFS_LOW_PERIOD, 16'hFFFF);
    wr(OFS_CONTROL_ONE_HIGH, 16'h0003);
    wr(OFS_CONTROL_ONE_LOW, 16'h8000);
    cyc(40);
    ccp_far_end_inst.pulse_src(5'h03);
    rd(OFS_LOW_COUNTER);
    chk("sync clr", {15'h0, v < 16'h000A}, 16'h0001);
    wr(OFS_CONTROL_ONE_LOW, 16'h0000);
    wr(OFS_CONTROL_ONE_HIGH, 16'h0082);
    wr(OFS_CONTROL_ONE_LOW, 16'h8000);
    cyc(10);
    rd(OFS_LOW_COUNTER);
    chk("held", v, 16'h0000);
    ccp_far_end_inst.pulse_src(5'h02);
    rd(OFS_STATUS_LOW);
    chk("trig", v & 16'h0080, 16'h0080);
    rd(OFS_LOW_COUNTER);
    chk("run", {15'h0, v != 16'h0000}, 16'h0001);
    wr(OFS_STATUS_LOW, 16'h0020);
    cyc(5);
    rd(OFS_LOW_COUNTER);
    chk("trigger_clear", v, 16'h0000);
    rd(OFS_STATUS_LOW);
    chk("trig off", v & 16'h0080, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      wr(OFS_CONTROL_ONE_LOW, 16'h0000);
      wr(OFS_CONTROL_ONE_LOW, 16'h8010 | 16'(modes[i]));
      ccp_far_end_inst.pulse_pin(rises[i] - 1);
      cyc(4);
      rd(OFS_STATUS_LOW);
      chk("fifo early", v & 16'h0001, 16'h0000);
      ccp_far_end_inst.pulse_pin(1);
      cyc(4);
      rd(OFS_STATUS_LOW);
      chk("fifo", v & 16'h0001, 16'h0001);
      rd(OFS_LOW_COUNTER);
      chk("cap live", {15'h0, v != 16'h0000}, 16'h0001);
      rd(OFS_CAPTURE_LOW);
      rd(OFS_CAPTURE_HIGH);
      chk("cap hi", v, 16'h0000);
      repeat (3) begin
        rd(OFS_CAPTURE_LOW);
        rd(OFS_CAPTURE_HIGH);
      end
      rd(OFS_STATUS_LOW);
      chk("drained", v & 16'h0003, 16'h0000);
    end
    cyc(2);
    end_sim();
  end
endmodule
`default_nettype wire
